// ===== scf_front_end.v
`include "scf_map.vh"
`default_nettype none

module scf_front_end #(
    parameter [31:0] LOF_CYC = `SCF_LOF_CYC,
    parameter [31:0] LOS_CYC = `SCF_LOS_CYC,
    parameter [31:0] BEAT_CYC = `SCF_BEAT_CYC,
    parameter [31:0] PPS_CYC = `SCF_PPS_CYC
) (
    input wire I_CLK_SYS,
    input wire I_RESETN,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    // Board status
    input wire I_UPPER_CFG_DONE,
    input wire I_LOWER_CFG_DONE,
    input wire I_IMAGE_VARLEN,
    input wire I_CAPTURE_RUN,
    input wire I_SECOND_PULSE_INPUT,
    // Framer status
    input wire I_RX_LINE_BIT,
    input wire I_FRAMER_OOF,
    input wire I_FRAMER_LOP,
    input wire I_FRAMER_LCD,
    // Record verdict request
    input wire I_REC_DONE,
    input wire [15:0] I_REC_LEN,
    input wire I_REC_IDLE,
    input wire I_REC_HEC_ONE,
    input wire I_REC_HEC_MULTI,
    input wire I_REC_FRAME_CHECK_SHORT_OK,
    input wire I_REC_FRAME_CHECK_LONG_OK,
    // Record verdict answer
    output reg O_REC_KEEP,
    output reg O_REC_DROP,
    output reg O_REC_PAD,
    output reg [15:0] O_REC_CAP_LEN,
    // Framer controls, alarms and lamps
    output reg O_FRAMER_RESET,
    output reg O_ATM_MODE,
    output reg O_OC12_SEL,
    output reg O_FACILITY_LOOP,
    output reg O_TX_CLK_SLAVE,
    output reg O_LOOP_TIMER_ONE,
    output reg O_LOOP_TIMER_ZERO,
    output reg O_SONET_DESCR_EN,
    output reg O_POS_DESCR_EN,
    output reg O_ATM_DESCR_EN,
    output reg [1:0] O_FRAME_CHECK_SEL,
    output reg O_LOS,
    output reg O_LOF,
    output reg [7:0] O_LED
);

    // --------------------------------------------------------
    // Register storage
    // --------------------------------------------------------
    reg [`SCF_CTRL_W-1:0] ctrl_r; // Control word
    reg [15:0] snap_r; // Programmed snap length
    reg [31:0] prdata_nxt; // Read mux result
    reg hit_nxt; // Address decodes
    reg pps_alive_r; // Pulse seen recently, read back in status

    // Decoded control fields
    wire atm_w = ctrl_r[`SCF_CTRL_ATM];
    wire [1:0] chk_w = ctrl_r[`SCF_CTRL_CRC_HI:`SCF_CTRL_CRC_LO];
    // ATM forces fixed length and no variable records
    wire varlen_w = ctrl_r[`SCF_CTRL_VARLEN] & ~atm_w;
    wire [15:0] slen_w = atm_w ? `SCF_SNAP_ATM : snap_r;

    // --------------------------------------------------------
    // APB access phase
    // --------------------------------------------------------
    // Answer one cycle into the access phase; pready drops after
    wire acc_w = I_PSEL & I_PENABLE & ~O_PREADY;

    // Read mux and decode
    always @* begin
        prdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (I_PADDR)
            `SCF_OFS_CTRL: begin
                prdata_nxt = {14'h0000, ctrl_r};
            end
            `SCF_OFS_SNAP: begin
                prdata_nxt = {slen_w, snap_r};
            end
            `SCF_OFS_STAT: begin
                prdata_nxt = {slen_w, 8'h00, 1'b0, varlen_w, pps_alive_r,
                    I_FRAMER_LCD, I_FRAMER_LOP, I_FRAMER_OOF, O_LOF, O_LOS};
            end
            default: begin
                // Unmapped word reads as zero with an error
                hit_nxt = 1'b0;
            end
        endcase
    end

    // Bus answer and register writes
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            ctrl_r <= `SCF_CTRL_RST;
            snap_r <= `SCF_SNAP_RST;
        end else begin
            O_PREADY <= acc_w;
            O_PSLVERR <= acc_w & ~hit_nxt;
            if (acc_w && !I_PWRITE) begin
                O_PRDATA <= prdata_nxt;
            end
            if (acc_w && I_PWRITE) begin
                // Writes land in the cycle pready is raised
                if (I_PADDR == `SCF_OFS_CTRL) begin
                    ctrl_r <= I_PWDATA[`SCF_CTRL_W-1:0];
                end
                if (I_PADDR == `SCF_OFS_SNAP) begin
                    snap_r <= I_PWDATA[15:0];
                end
            end
        end
    end

    // --------------------------------------------------------
    // Framer control outputs
    // --------------------------------------------------------
    // Registered copies so every pin comes from a flop
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_FRAMER_RESET <= 1'b0;
            O_ATM_MODE <= 1'b0;
            O_OC12_SEL <= 1'b0;
            O_FACILITY_LOOP <= 1'b0;
            O_TX_CLK_SLAVE <= 1'b0;
            O_LOOP_TIMER_ONE <= 1'b0;
            O_LOOP_TIMER_ZERO <= 1'b0;
            O_SONET_DESCR_EN <= 1'b0;
            O_POS_DESCR_EN <= 1'b0;
            O_ATM_DESCR_EN <= 1'b0;
            O_FRAME_CHECK_SEL <= `SCF_CHK_NONE;
        end else begin
            O_FRAMER_RESET <= ctrl_r[`SCF_CTRL_FRST];
            O_ATM_MODE <= atm_w;
            O_OC12_SEL <= ctrl_r[`SCF_CTRL_OC12];
            O_FACILITY_LOOP <= ctrl_r[`SCF_CTRL_LOOP];
            O_TX_CLK_SLAVE <= ctrl_r[`SCF_CTRL_SLAVE];
            O_LOOP_TIMER_ONE <= ctrl_r[`SCF_CTRL_LT1];
            O_LOOP_TIMER_ZERO <= ctrl_r[`SCF_CTRL_LT0];
            O_SONET_DESCR_EN <= ctrl_r[`SCF_CTRL_SDESC];
            // Packet descramble only matters in packet mode
            O_POS_DESCR_EN <= ctrl_r[`SCF_CTRL_PDESC] & ~atm_w;
            O_ATM_DESCR_EN <= ctrl_r[`SCF_CTRL_ADESC] & atm_w;
            // Frame check is a packet-only feature
            O_FRAME_CHECK_SEL <= atm_w ? `SCF_CHK_NONE : chk_w;
        end
    end

    // --------------------------------------------------------
    // Record verdict
    // --------------------------------------------------------
    reg chk_ok_nxt; // Frame check verdict
    reg len_ok_nxt; // Length window verdict
    reg cell_ok_nxt; // Cell verdict
    reg keep_nxt; // Final verdict

    always @* begin
        case (chk_w)
            `SCF_CHK_SHORT: begin
                chk_ok_nxt = I_REC_FRAME_CHECK_SHORT_OK;
            end
            `SCF_CHK_LONG: begin
                chk_ok_nxt = I_REC_FRAME_CHECK_LONG_OK;
            end
            default: begin
                chk_ok_nxt = 1'b1;
            end
        endcase
        // Limits are fixed build constants, not software values
        len_ok_nxt = ~(ctrl_r[`SCF_CTRL_PMIN] & (I_REC_LEN < `SCF_MIN_LEN)) &
            ~(ctrl_r[`SCF_CTRL_PMAX] & (I_REC_LEN > `SCF_MAX_LEN));
        // Single-bit header errors survive only when fixing is on
        cell_ok_nxt = ~I_REC_HEC_MULTI &
            (~I_REC_HEC_ONE | ctrl_r[`SCF_CTRL_HFIX]) &
            (~I_REC_IDLE | ctrl_r[`SCF_CTRL_IDLE]);
        keep_nxt = atm_w ? cell_ok_nxt : (chk_ok_nxt & len_ok_nxt);
    end

    // Verdict is a one-cycle pulse the cycle after the request
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_REC_KEEP <= 1'b0;
            O_REC_DROP <= 1'b0;
            O_REC_PAD <= 1'b0;
            O_REC_CAP_LEN <= 16'h0000;
        end else begin
            O_REC_KEEP <= I_REC_DONE & keep_nxt;
            O_REC_DROP <= I_REC_DONE & ~keep_nxt;
            if (I_REC_DONE) begin
                // Fixed records pad out to the snap length
                O_REC_PAD <= keep_nxt & ~varlen_w;
                if (varlen_w && (I_REC_LEN < slen_w)) begin
                    O_REC_CAP_LEN <= I_REC_LEN;
                end else begin
                    O_REC_CAP_LEN <= slen_w;
                end
            end else begin
                O_REC_PAD <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------
    // Loss of signal and loss of frame timers
    // --------------------------------------------------------
    reg line_prev_r; // Last line bit
    reg [31:0] los_cnt_r; // Cycles since a rising transition
    reg [31:0] lof_cnt_r; // Cycles out of frame

    // Counters saturate so a dead line never wraps back to good
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            line_prev_r <= 1'b0;
            los_cnt_r <= 32'h0000_0000;
            lof_cnt_r <= 32'h0000_0000;
            O_LOS <= 1'b0;
            O_LOF <= 1'b0;
        end else begin
            line_prev_r <= I_RX_LINE_BIT;
            if (I_RX_LINE_BIT && !line_prev_r) begin
                los_cnt_r <= 32'h0000_0000;
                O_LOS <= 1'b0;
            end else if (los_cnt_r < LOS_CYC) begin
                los_cnt_r <= los_cnt_r + 32'h0000_0001;
            end else begin
                O_LOS <= 1'b1;
            end
            if (!I_FRAMER_OOF) begin
                lof_cnt_r <= 32'h0000_0000;
                O_LOF <= 1'b0;
            end else if (lof_cnt_r < LOF_CYC) begin
                lof_cnt_r <= lof_cnt_r + 32'h0000_0001;
            end else begin
                // Out of frame longer than the window
                O_LOF <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------
    // Heartbeat and second pulse tracking
    // --------------------------------------------------------
    reg [31:0] beat_cnt_r; // Heartbeat cycle counter
    reg beat_r; // Heartbeat lamp state
    reg pps_prev_r; // Last second pulse level
    reg pps_tgl_r; // Flips on each received pulse
    reg [31:0] pps_cnt_r; // Cycles since last pulse

    // On half the second, off the other half
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            beat_cnt_r <= 32'h0000_0000;
            beat_r <= 1'b0;
        end else if (beat_cnt_r >= BEAT_CYC - 32'h0000_0001) begin
            beat_cnt_r <= 32'h0000_0000;
            beat_r <= 1'b1;
        end else begin
            beat_cnt_r <= beat_cnt_r + 32'h0000_0001;
            // Clear one count early so lit and dark spans are equal
            if (beat_cnt_r == (BEAT_CYC >> 1) - 32'h0000_0001) begin
                beat_r <= 1'b0;
            end
        end
    end

    // A missing cable lets the lamp settle dark, never stuck lit
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            pps_prev_r <= 1'b0;
            pps_tgl_r <= 1'b0;
            pps_alive_r <= 1'b0;
            pps_cnt_r <= 32'h0000_0000;
        end else begin
            pps_prev_r <= I_SECOND_PULSE_INPUT;
            if (I_SECOND_PULSE_INPUT && !pps_prev_r) begin
                pps_tgl_r <= ~pps_tgl_r;
                pps_alive_r <= 1'b1;
                pps_cnt_r <= 32'h0000_0000;
            end else if (pps_cnt_r < PPS_CYC) begin
                pps_cnt_r <= pps_cnt_r + 32'h0000_0001;
            end else begin
                pps_alive_r <= 1'b0;
                pps_tgl_r <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------
    // Indicator lamps
    // --------------------------------------------------------
    reg [7:0] led_nxt; // Lamp pattern for the loaded image

    always @* begin
        led_nxt[0] = I_UPPER_CFG_DONE;
        led_nxt[1] = I_LOWER_CFG_DONE;
        led_nxt[5] = O_LOF;
        led_nxt[6] = I_FRAMER_LOP;
        // Packet mode has no cells, so delineation never locks
        led_nxt[7] = I_FRAMER_LCD | ~atm_w;
        if (I_IMAGE_VARLEN) begin
            led_nxt[2] = I_CAPTURE_RUN;
            led_nxt[3] = atm_w;
            // Only this lamp may flash in the variable image
            led_nxt[4] = pps_tgl_r & pps_alive_r;
        end else begin
            led_nxt[2] = beat_r;
            led_nxt[3] = ctrl_r[`SCF_CTRL_ULED];
            // Signal-loss lamp clears on a line rise, frame-loss lamp once back in frame
            led_nxt[4] = O_LOS;
            led_nxt[5] = O_LOF;
        end
    end

    // Lamp register
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_LED <= 8'h00;
        end else begin
            O_LED <= led_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== scf_front_end_chk.sv
`default_nettype none
module scf_front_end_chk #(
    parameter [31:0] LOF_CYC = 32'h14,
    parameter [31:0] LOS_CYC = 32'h0A
) (
    input wire I_CLK_SYS,
    input wire I_RESETN,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire [7:0] I_PADDR,
    input wire I_UPPER_CFG_DONE,
    input wire I_RX_LINE_BIT,
    input wire I_FRAMER_OOF,
    input wire I_FRAMER_LCD,
    input wire I_REC_DONE,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire O_REC_KEEP,
    input wire O_REC_DROP,
    input wire [15:0] O_REC_CAP_LEN,
    input wire O_ATM_MODE,
    input wire O_LOS,
    input wire O_LOF,
    input wire [7:0] O_LED
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line_r;
    logic [9:0] quiet_r, quiet_nxt, oof_r, oof_nxt;
    logic [2:0] age_r, age_nxt;
    // ----------------------------------------
    // Run lengths, saturating so they never wrap
    // ----------------------------------------
    always_comb begin
        quiet_nxt = (I_RX_LINE_BIT && !line_r) ? 10'h0 : quiet_r + {9'h0, quiet_r != 10'h3FF};
        oof_nxt = I_FRAMER_OOF ? oof_r + {9'h0, oof_r != 10'h3FF} : 10'h0;
        age_nxt = age_r + {2'h0, age_r != 3'h7};
    end
    always_ff @(posedge I_CLK_SYS) begin
        line_r <= I_RX_LINE_BIT;
        quiet_r <= I_RESETN ? quiet_nxt : 10'h0;
        oof_r <= I_RESETN ? oof_nxt : 10'h0;
        age_r <= I_RESETN ? age_nxt : 3'h0;
    end
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESETN);
    sequence s_apb_req;
        I_PSEL && I_PENABLE && !O_PREADY;
    endsequence
    sequence s_oof_quiet;
        !I_FRAMER_OOF [*2];
    endsequence
    a_pready_pulse: assert property (s_apb_req |=> O_PREADY ##1 !O_PREADY)
        else $error("ready is not a single pulse after access");
    a_slverr_map: assert property (s_apb_req |=> O_PSLVERR ==
        (I_PADDR != 8'h00 && I_PADDR != 8'h04 && I_PADDR != 8'h08))
        else $error("error response does not match address map");
    a_verdict_once: assert property (I_REC_DONE |=> O_REC_KEEP != O_REC_DROP)
        else $error("record verdict missing or doubled");
    a_atm_snap: assert property (I_REC_DONE && O_ATM_MODE |=> O_REC_CAP_LEN == 16'h0034)
        else $error("cell record length wrong");
    a_cfg_lamp: assert property (age_r > 3'h2 |-> O_LED[0] == $past(I_UPPER_CFG_DONE))
        else $error("configured lamp does not follow input");
    a_cell_lamp: assert property (age_r > 3'h2 && $stable(O_ATM_MODE) |->
        O_LED[7] == ($past(I_FRAMER_LCD) || !O_ATM_MODE))
        else $error("delineation lamp wrong");
    a_los_quiet: assert property (quiet_r > 10'h2 && quiet_r < LOS_CYC - 2 |-> !O_LOS)
        else $error("signal loss raised while line toggles");
    a_los_set: assert property (quiet_r > LOS_CYC + 3 |-> O_LOS)
        else $error("signal loss not raised");
    a_lof_set: assert property (oof_r > LOF_CYC + 3 |-> O_LOF)
        else $error("frame loss not raised");
    a_lof_clear: assert property (s_oof_quiet |=> !O_LOF)
        else $error("frame loss not cleared");
    a_lof_lamp: assert property (age_r > 3'h3 && $stable(O_LOF) && O_LOF == $past(O_LOF, 2)
        |-> O_LED[5] == O_LOF)
        else $error("frame loss lamp wrong");
endmodule
`default_nettype wire

// ===== scf_line_model.sv
`default_nettype none
module scf_line_model (
    input wire logic i_clk,
    input wire logic i_light,
    input wire logic i_line_oc12,
    input wire logic i_oc12_sel,
    input wire logic i_atm_mode,
    output logic o_line_bit,
    output logic o_oof,
    output logic o_lop,
    output logic o_lcd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic match;
    // Lock forms only with light and the right rate
    assign match = i_light && (i_line_oc12 == i_oc12_sel);
    // Lit fibre toggles; a dark one has no transitions at all
    always @(posedge i_clk) o_line_bit <= i_light && !o_line_bit;
    assign o_oof = !match;
    assign o_lop = i_light && !match;
    // Line carries cells; packet framing never delineates them
    assign o_lcd = !(match && i_atm_mode);
endmodule
`default_nettype wire

// ===== scf_map.vh
// Function
// - LED1 upper logic done, LED2 lower done
// - Variable image: LED3 shows capture running
// - Variable image: LED4 shows ATM mode
// - Variable image: LED5 shows second pulse
// - LED6 lit while frame lost
// - LED7 lit while pointer lock lost
// - LED8 cell delineation lost, always in packet
// - Fixed image: LED3 flashes as heartbeat
// - Heartbeat flashes once per second
// - Fixed image: LED5 out with signal, LED6 out in frame
// - Variable image: flash only with second pulse
// - Receive mode ATM cells or packets
// - Line rate select OC3c or OC12c
// - Control holds framer in reset
// - Facility loopback retransmits received line
// - Transmit clock internal or recovered
// - Packet check none, short or long
// - Enables discard too short, too long
// - Header single-bit errors corrected when enabled
// - Idle cells forwarded only when enabled
// - Cell payload descramble when enabled
// - Snap length default 48, ATM 52
// - Pad to snap unless variable; ATM fixed
// - Frame loss after 3 ms out-of-frame
// - Signal loss after 20 us no rise
`ifndef SCF_MAP_VH
`define SCF_MAP_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define SCF_OFS_CTRL 8'h00
`define SCF_OFS_SNAP 8'h04
`define SCF_OFS_STAT 8'h08

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define SCF_CTRL_ATM 0
`define SCF_CTRL_OC12 1
`define SCF_CTRL_FRST 2
`define SCF_CTRL_LOOP 3
`define SCF_CTRL_SLAVE 4
`define SCF_CTRL_SDESC 5
`define SCF_CTRL_PDESC 6
`define SCF_CTRL_CRC_LO 7
`define SCF_CTRL_CRC_HI 8
`define SCF_CTRL_PMIN 9
`define SCF_CTRL_PMAX 10
`define SCF_CTRL_HFIX 11
`define SCF_CTRL_IDLE 12
`define SCF_CTRL_ADESC 13
`define SCF_CTRL_VARLEN 14
`define SCF_CTRL_LT1 15
`define SCF_CTRL_LT0 16
`define SCF_CTRL_ULED 17
`define SCF_CTRL_W 18
`define SCF_CTRL_RST 18'h0E070

// Frame check selections
`define SCF_CHK_NONE 2'h0
`define SCF_CHK_SHORT 2'h1
`define SCF_CHK_LONG 2'h2

// ------------------------------------------------------------
// Capture lengths
// ------------------------------------------------------------
`define SCF_SNAP_RST 16'h0030
`define SCF_SNAP_ATM 16'h0034
`define SCF_MIN_LEN 16'h0004
`define SCF_MAX_LEN 16'h2000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCF_CLK_MHZ 250
`define SCF_LOF_TIME_US 3000
`define SCF_LOS_TIME_US 20
`define SCF_BEAT_TIME_US 1000000
`define SCF_PPS_TIME_US 2000000
`define SCF_LOF_CYC (`SCF_LOF_TIME_US * `SCF_CLK_MHZ)
`define SCF_LOS_CYC (`SCF_LOS_TIME_US * `SCF_CLK_MHZ)
`define SCF_BEAT_CYC (`SCF_BEAT_TIME_US * `SCF_CLK_MHZ)
`define SCF_PPS_CYC (`SCF_PPS_TIME_US * `SCF_CLK_MHZ)

`endif

// ===== tb_sonet_capture_front_end_config.sv
`include "scf_map.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_sonet_capture_front_end_config;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] LOFC = 32'h14, LOSC = 32'h0A, BEATC = 32'h10, PPSC = 32'h28;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, up_d = 0, lo_d = 0, img_var = 1;
    logic cap_run = 0, second_pulse_input = 0, rec_done = 0, r_idle = 0, h1 = 0, hm = 0, ok_s = 0, ok_l = 0;
    logic light = 0, line_oc12 = 0, bg_on = 0, cap_q, up_q, atm_q, e, b;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [15:0] r_len = 0, slen_m = 16'h0030;
    logic [17:0] ctrl_m;
    wire [31:0] prdata;
    wire [15:0] cap_len;
    wire [7:0] led;
    wire [1:0] csel;
    wire pready, pslverr, keep, drop, pad, frst, atm, oc12, floop, slave, lt1, lt0, sdesc;
    wire pdesc, adesc, los, lof, line_bit, oof, lop, lcd;
    int errors = 0, n_compared = 0, n;
    scf_front_end #(.LOF_CYC(LOFC), .LOS_CYC(LOSC), .BEAT_CYC(BEATC), .PPS_CYC(PPSC)) dut (
        .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_UPPER_CFG_DONE(up_d), .I_LOWER_CFG_DONE(lo_d),
        .I_IMAGE_VARLEN(img_var), .I_CAPTURE_RUN(cap_run), .I_SECOND_PULSE_INPUT(second_pulse_input),
        .I_RX_LINE_BIT(line_bit), .I_FRAMER_OOF(oof), .I_FRAMER_LOP(lop), .I_FRAMER_LCD(lcd),
        .I_REC_DONE(rec_done), .I_REC_LEN(r_len), .I_REC_IDLE(r_idle), .I_REC_HEC_ONE(h1),
        .I_REC_HEC_MULTI(hm), .I_REC_FRAME_CHECK_SHORT_OK(ok_s), .I_REC_FRAME_CHECK_LONG_OK(ok_l),
        .O_REC_KEEP(keep), .O_REC_DROP(drop), .O_REC_PAD(pad), .O_REC_CAP_LEN(cap_len),
        .O_FRAMER_RESET(frst), .O_ATM_MODE(atm), .O_OC12_SEL(oc12), .O_FACILITY_LOOP(floop),
        .O_TX_CLK_SLAVE(slave), .O_LOOP_TIMER_ONE(lt1), .O_LOOP_TIMER_ZERO(lt0),
        .O_SONET_DESCR_EN(sdesc), .O_POS_DESCR_EN(pdesc), .O_ATM_DESCR_EN(adesc),
        .O_FRAME_CHECK_SEL(csel), .O_LOS(los), .O_LOF(lof), .O_LED(led));
    scf_line_model u_line (.i_clk(clk), .i_light(light), .i_line_oc12(line_oc12),
        .i_oc12_sel(oc12), .i_atm_mode(atm), .o_line_bit(line_bit), .o_oof(oof), .o_lop(lop),
        .o_lcd(lcd));
    initial forever #2 clk = !clk;
    // Random board status; lamps checked one cycle behind their source
    always @(posedge clk) begin
        if (bg_on) begin
            `CHK("run lamp", cap_q, led[2])
            `CHK("cfg lamp", up_q, led[0])
            if (atm === atm_q) `CHK("atm lamp", atm, led[3])
        end
        cap_q = cap_run;
        up_q = up_d;
        atm_q = atm;
        cap_run <= $urandom;
        up_d <= $urandom;
        lo_d <= 1'b1;
    end
    // One APB transfer; waits for ready without assuming its latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic setc(input logic [17:0] c);
        apb(1'b1, 8'h00, {14'h0, c});
        ctrl_m = c;
        repeat (3) @(posedge clk);
    endtask
    // Record verdict against the model built from the mode bits
    task automatic rec(input logic [15:0] len);
        logic [4:0] r;
        logic k, va;
        r = 5'($urandom);
        if (ctrl_m[0]) k = !r[1] && (!r[0] || ctrl_m[11]) && (!r[2] || ctrl_m[12]);
        else k = (ctrl_m[8:7] == 2'h0 || (ctrl_m[8:7] == 2'h1 && r[3]) || (ctrl_m[8:7] == 2'h2
            && r[4])) && !(ctrl_m[9] && len < 16'h4) && !(ctrl_m[10] && len > 16'h2000);
        va = ctrl_m[14] && !ctrl_m[0];
        @(posedge clk);
        {ok_l, ok_s, r_idle, hm, h1} <= r;
        r_len <= len;
        rec_done <= 1'b1;
        @(posedge clk);
        rec_done <= 1'b0;
        @(posedge clk);
        `CHK("keep", {k, !k}, {keep, drop})
        `CHK("pad", k && !va, pad)
        `CHK("len", ctrl_m[0] ? 16'h0034 : (va && len < slen_m) ? len : slen_m, cap_len)
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h4B13));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        bg_on <= 1'b1;
        `CHK("ctrl rst", {14'h0, `SCF_CTRL_RST}, q)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("snap rst", 32'h00300030, q)
        `CHK("slave rst", 2'h3, {slave, lt1})
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped", 33'h100000000, {e, q})
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            ctrl_m = 18'($urandom);
            ctrl_m[0] = i[0];
            ctrl_m[8:7] = (i[2:1] == 2'h3) ? 2'h2 : i[2:1];
            setc(ctrl_m);
            apb(1'b0, 8'h00, 32'h0);
            `CHK("ctrl rd", {14'h0, ctrl_m}, q)
            `CHK("mode rate", ctrl_m[1:0], {oc12, atm})
            `CHK("reset loop", ctrl_m[4:2], {slave, floop, frst})
            `CHK("descr", {ctrl_m[5], ctrl_m[6] & !i[0], ctrl_m[13] & i[0]}, {sdesc, pdesc, adesc})
            `CHK("check", i[0] ? 2'h0 : ctrl_m[8:7], csel)
            `CHK("timers", ctrl_m[16:15], {lt0, lt1})
            slen_m = 16'h1 + 16'($urandom_range(0, 199));
            apb(1'b1, 8'h04, {16'h0, slen_m});
            for (int j = 0; j < 10; j++) rec(j == 0 ? 16'h3 : j == 1 ? 16'h4 : j == 2 ? 16'h2000
                : j == 3 ? 16'h2001 : 16'($urandom_range(1, 300)));
        end
        $display("test control and records done");
        repeat (PPSC + 4) @(posedge clk);
        `CHK("pps idle", 1'b0, led[4])
        repeat (3) begin
            b = led[4];
            second_pulse_input <= 1'b1;
            @(posedge clk);
            second_pulse_input <= 1'b0;
            repeat (4) @(posedge clk);
            `CHK("pps pulse", !b, led[4])
        end
        repeat (PPSC + 8) @(posedge clk);
        `CHK("pps lost", 1'b0, led[4])
        $display("test second pulse done");
        light <= 1'b1;
        line_oc12 <= 1'b1;
        setc(`SCF_CTRL_RST | 18'h2);
        repeat (LOFC + 8) @(posedge clk);
        `CHK("locked", 5'h04, {los, lof, led[7:5]})
        setc(`SCF_CTRL_RST | 18'h3);
        `CHK("cells", 3'h0, led[7:5])
        light <= 1'b0;
        repeat (LOFC + LOSC + 8) @(posedge clk);
        `CHK("dark", 4'hF, {los, lof, led[5], led[7]})
        light <= 1'b1;
        line_oc12 <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("rate", 3'h3, {los, led[6], lof})
        $display("test line done");
        bg_on <= 1'b0;
        img_var <= 1'b0;
        line_oc12 <= 1'b1;
        repeat (LOFC + 8) @(posedge clk);
        `CHK("fixed lit", 2'h0, led[5:4])
        n = 0;
        repeat (2 * BEATC) begin
            @(posedge clk);
            n += led[2];
        end
        `CHK("beat", BEATC, 32'(n))
        light <= 1'b0;
        repeat (LOSC + 8) @(posedge clk);
        `CHK("fixed dark", 1'b1, led[4])
        $display("test fixed image done");
        conclude();
    end
endmodule
bind scf_front_end scf_front_end_chk #(.LOF_CYC(LOF_CYC), .LOS_CYC(LOS_CYC)) u_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PADDR(I_PADDR), .I_UPPER_CFG_DONE(I_UPPER_CFG_DONE), .I_RX_LINE_BIT(I_RX_LINE_BIT),
    .I_FRAMER_OOF(I_FRAMER_OOF), .I_FRAMER_LCD(I_FRAMER_LCD), .I_REC_DONE(I_REC_DONE),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_REC_KEEP(O_REC_KEEP),
    .O_REC_DROP(O_REC_DROP), .O_REC_CAP_LEN(O_REC_CAP_LEN), .O_ATM_MODE(O_ATM_MODE),
    .O_LOS(O_LOS), .O_LOF(O_LOF), .O_LED(O_LED));
`default_nettype wire
